// ### common/bsd_pkg.sv
// Constants and types for the boot-strap decoder
// What this block does
// - Strap bits 2..0 pick PLL reference: 19.2,20,24,25,26,27 MHz; 110/111 reserved.
// - Strap bits 6..3 pick the primary boot device; 0000, 0100, 0101 reserved.
// - Strap bits 12..10 pick the backup boot device; 010 and 100 reserved.
// - Backup is tried after primary fails, or at once for a reserved primary code; never when backup is none.
// - Strap bit 13 configures backup: mode for USB, port for MMC/SD, else reserved.
// - Straps are set before power-up and taken at the end of power-on reset.
package bsd_pkg;

  // ----------------------------------------
  // Strap word layout
  // ----------------------------------------
  localparam int unsigned BSD_STRAP_W = 16;
  localparam int unsigned BSD_PLL_LSB = 0;
  localparam int unsigned BSD_PRI_LSB = 3;
  localparam int unsigned BSD_PCFG_LSB = 7;
  localparam int unsigned BSD_BAK_LSB = 10;
  localparam int unsigned BSD_BCFG_BIT = 13;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [2:0] BSD_PLL_19M2 = 3'h0;
  localparam logic [2:0] BSD_PLL_20M = 3'h1;
  localparam logic [2:0] BSD_PLL_24M = 3'h2;
  localparam logic [2:0] BSD_PLL_25M = 3'h3;
  localparam logic [2:0] BSD_PLL_26M = 3'h4;
  localparam logic [2:0] BSD_PLL_27M = 3'h5;
  localparam logic [3:0] BSD_PRI_RSVD0 = 4'h0;
  localparam logic [3:0] BSD_PRI_RSVD4 = 4'h4;
  localparam logic [3:0] BSD_PRI_RSVD5 = 4'h5;
  localparam logic [3:0] BSD_PRI_NOBOOT = 4'hf;
  localparam logic [2:0] BSD_BAK_NONE = 3'h0;
  localparam logic [2:0] BSD_BAK_USB = 3'h1;
  localparam logic [2:0] BSD_BAK_RSVD2 = 3'h2;
  localparam logic [2:0] BSD_BAK_UART = 3'h3;
  localparam logic [2:0] BSD_BAK_RSVD4 = 3'h4;
  localparam logic [2:0] BSD_BAK_MMCSD = 3'h5;
  localparam logic [2:0] BSD_BAK_SPI = 3'h6;
  localparam logic [2:0] BSD_BAK_I2C = 3'h7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] BSD_STRAP_RST = 16'h0000;
  localparam logic BSD_PIN_RST = 1'b0;

  // Boot sequencing states
  typedef enum logic [2:0] {
    BSD_ST_HOLD,
    BSD_ST_PRIMARY,
    BSD_ST_BACKUP,
    BSD_ST_DONE,
    BSD_ST_HALT
  } bsd_state_t;

endpackage

// ### rtl/bsd_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bsd_sync
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= bsd_pkg::BSD_PIN_RST;
      s2_q <= bsd_pkg::BSD_PIN_RST;
      s3_q <= bsd_pkg::BSD_PIN_RST;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_o <= bsd_pkg::BSD_PIN_RST;
    else if (s2_q == s3_q)
      level_o <= s3_q;
  end

endmodule

// ### rtl/bsd_top.sv
// Boot-strap word capture, field decode and primary/backup boot sequencing
`timescale 1ns/1ps
module bsd_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins from the board
  input wire logic [15:0] strap_i,
  input wire logic cold_reset_n_i,
  input wire logic main_warm_reset_n_i,
  // Boot attempt results from the loader
  input wire logic boot_ok_i,
  input wire logic boot_fail_i,
  // Captured selection
  output logic strap_valid_o,
  output logic [2:0] pll_ref_sel_o,
  output logic pll_ref_rsvd_o,
  output logic [3:0] primary_sel_o,
  output logic primary_rsvd_o,
  output logic [2:0] primary_cfg_o,
  output logic [2:0] backup_sel_o,
  output logic backup_rsvd_o,
  output logic backup_cfg_o,
  // Boot sequencing
  output logic try_primary_o,
  output logic try_backup_o,
  output logic boot_done_o,
  output logic boot_halt_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int unsigned PIN_N = 18;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic [15:0] strap_lvl;
  logic cold_lvl;
  logic warm_lvl;
  logic cold_prev_q;
  logic capture;
  logic [2:0] pll_f;
  logic [3:0] pri_f;
  logic [2:0] bak_f;
  logic bak_has_cfg;
  logic pri_rsvd_f;
  logic bak_rsvd_f;
  bsd_pkg::bsd_state_t state_q;
  bsd_pkg::bsd_state_t state_d;
  logic backup_usable;

  assign pin_raw = {main_warm_reset_n_i, cold_reset_n_i, strap_i};

  // One filter per pin; resets read as asserted until proven released
  generate
    for (genvar i = 0; i < PIN_N; i++)
    begin : g_sync
      bsd_sync u_sync
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_raw[i]),
        .level_o(pin_lvl[i])
      );
    end
  endgenerate

  assign strap_lvl = pin_lvl[15:0];
  assign cold_lvl = pin_lvl[16];
  assign warm_lvl = pin_lvl[17];

  // ----------------------------------------
  // Capture at end of power-on reset
  // ----------------------------------------
  // Release edge of cold reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cold_prev_q <= 1'b0;
    else
      cold_prev_q <= cold_lvl;
  end

  assign capture = cold_lvl && !cold_prev_q;

  // Field slicing; bits 15..14 are never looked at
  assign pll_f = strap_lvl[bsd_pkg::BSD_PLL_LSB +: 3];
  assign pri_f = strap_lvl[bsd_pkg::BSD_PRI_LSB +: 4];
  assign bak_f = strap_lvl[bsd_pkg::BSD_BAK_LSB +: 3];
  assign pri_rsvd_f = (pri_f == bsd_pkg::BSD_PRI_RSVD0) ||
                      (pri_f == bsd_pkg::BSD_PRI_RSVD4) ||
                      (pri_f == bsd_pkg::BSD_PRI_RSVD5);
  assign bak_rsvd_f = (bak_f == bsd_pkg::BSD_BAK_RSVD2) ||
                      (bak_f == bsd_pkg::BSD_BAK_RSVD4);
  assign bak_has_cfg = (bak_f == bsd_pkg::BSD_BAK_USB) ||
                       (bak_f == bsd_pkg::BSD_BAK_MMCSD);

  // Word held from capture until the next power-on reset; warm reset keeps it.
  // Undriven straps pull down, so an empty board captures all zeros.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_valid_o <= 1'b0;
      pll_ref_sel_o <= bsd_pkg::BSD_STRAP_RST[2:0];
      pll_ref_rsvd_o <= 1'b0;
      primary_sel_o <= bsd_pkg::BSD_STRAP_RST[3:0];
      primary_rsvd_o <= 1'b0;
      primary_cfg_o <= bsd_pkg::BSD_STRAP_RST[2:0];
      backup_sel_o <= bsd_pkg::BSD_STRAP_RST[2:0];
      backup_rsvd_o <= 1'b0;
      backup_cfg_o <= 1'b0;
    end
    else if (!cold_lvl)
      strap_valid_o <= 1'b0;
    else if (capture)
    begin
      strap_valid_o <= 1'b1;
      pll_ref_sel_o <= pll_f;
      pll_ref_rsvd_o <= (pll_f > bsd_pkg::BSD_PLL_27M);
      primary_sel_o <= pri_f;
      primary_rsvd_o <= pri_rsvd_f;
      primary_cfg_o <= strap_lvl[bsd_pkg::BSD_PCFG_LSB +: 3];
      backup_sel_o <= bak_f;
      backup_rsvd_o <= bak_rsvd_f;
      // Reserved config bit is masked so loaders never see stray values
      backup_cfg_o <= bak_has_cfg && strap_lvl[bsd_pkg::BSD_BCFG_BIT];
    end
  end

  // ----------------------------------------
  // Boot sequencing
  // ----------------------------------------
  assign backup_usable = (backup_sel_o != bsd_pkg::BSD_BAK_NONE) && !backup_rsvd_o;

  // Next state; a reserved primary code counts as a failed primary
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bsd_pkg::BSD_ST_HOLD:
      begin
        if (strap_valid_o && cold_lvl && warm_lvl)
        begin
          if (primary_sel_o == bsd_pkg::BSD_PRI_NOBOOT)
            state_d = bsd_pkg::BSD_ST_HALT;
          else if (!primary_rsvd_o)
            state_d = bsd_pkg::BSD_ST_PRIMARY;
          else if (backup_usable)
            state_d = bsd_pkg::BSD_ST_BACKUP;
          else
            state_d = bsd_pkg::BSD_ST_HALT;
        end
      end
      bsd_pkg::BSD_ST_PRIMARY:
      begin
        if (boot_ok_i)
          state_d = bsd_pkg::BSD_ST_DONE;
        else if (boot_fail_i)
          state_d = backup_usable ? bsd_pkg::BSD_ST_BACKUP : bsd_pkg::BSD_ST_HALT;
      end
      bsd_pkg::BSD_ST_BACKUP:
      begin
        if (boot_ok_i)
          state_d = bsd_pkg::BSD_ST_DONE;
        else if (boot_fail_i)
          state_d = bsd_pkg::BSD_ST_HALT;
      end
      default:
        state_d = state_q;
    endcase
    // Either reset restarts the sequence: warm from the held word, cold from a new capture
    if (!cold_lvl || !warm_lvl)
      state_d = bsd_pkg::BSD_ST_HOLD;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= bsd_pkg::BSD_ST_HOLD;
    else
      state_q <= state_d;
  end

  // Registered status, aligned with the state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      try_primary_o <= 1'b0;
      try_backup_o <= 1'b0;
      boot_done_o <= 1'b0;
      boot_halt_o <= 1'b0;
    end
    else
    begin
      try_primary_o <= (state_d == bsd_pkg::BSD_ST_PRIMARY);
      try_backup_o <= (state_d == bsd_pkg::BSD_ST_BACKUP);
      boot_done_o <= (state_d == bsd_pkg::BSD_ST_DONE);
      boot_halt_o <= (state_d == bsd_pkg::BSD_ST_HALT);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_pll_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    capture |=> (pll_ref_sel_o == $past(strap_lvl[2:0])) &&
                (pll_ref_rsvd_o == ($past(strap_lvl[2:1]) == 2'b11)))
    else $error("pll reference field not captured");

  a_primary_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    capture |=> (primary_sel_o == $past(strap_lvl[6:3])) &&
                (primary_rsvd_o == ($past(strap_lvl[6:3]) inside {4'h0, 4'h4, 4'h5})))
    else $error("primary device field not captured");

  a_backup_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    capture |=> (backup_sel_o == $past(strap_lvl[12:10])) &&
                (backup_rsvd_o == ($past(strap_lvl[12:10]) inside {3'h2, 3'h4})))
    else $error("backup device field not captured");

  a_backup_cfg_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    backup_cfg_o |-> (backup_sel_o == 3'h1) || (backup_sel_o == 3'h5))
    else $error("backup config set for device without config");

  a_pcfg_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    capture |=> primary_cfg_o == $past(strap_lvl[9:7]))
    else $error("primary config not passed through");

  a_backup_not_none: assert property (@(posedge clk_i) disable iff (rst_i)
    try_backup_o |-> (backup_sel_o != 3'h0) && !backup_rsvd_o)
    else $error("backup attempted with none selected");

  a_backup_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(try_backup_o) |-> ($past(boot_fail_i) && $past(try_primary_o)) ||
                            (primary_rsvd_o && !$past(try_primary_o)))
    else $error("backup attempted without primary failure");

  a_hold_in_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    !cold_lvl |=> !strap_valid_o && !try_primary_o && !try_backup_o)
    else $error("boot activity during power-on reset");

  a_start_primary: assert property (@(posedge clk_i) disable iff (rst_i)
    capture && warm_lvl && !pri_rsvd_f && (pri_f != 4'hf) |=> ##1 try_primary_o)
    else $error("primary not started after power-on reset");

endmodule

// ### rtl/placeholder_unused.sv
// Intentionally empty compilation unit
`timescale 1ns/1ps

// ### verification/bsd_board.sv
// Board model: strap expander under automation control plus reset lines
`timescale 1ns/1ps
module bsd_board
(
  // Automation controller requests
  input wire logic [15:0] pattern_i,
  input wire logic load_i,
  input wire logic strap_expander_reset_i,
  input wire logic automation_cold_reset_n_i,
  input wire logic automation_warm_reset_n_i,
  input wire logic automation_power_off_i,
  // Pins toward the device
  output logic [15:0] strap_o,
  output logic cold_reset_n_o,
  output logic main_warm_reset_n_o
);
  logic [15:0] expander_q = 16'h0000;
  logic strap_buffer_enable_n;
  logic [15:0] switches;

  // ----------------------------------------
  // Strap path
  // ----------------------------------------
  // Under automation every switch is off and the buffer enable is low
  assign switches = 16'h0000;
  assign strap_buffer_enable_n = 1'b0;
  // Expander latches a written pattern; its reset clears outputs first
  always @(posedge load_i or posedge strap_expander_reset_i)
  begin
    if (strap_expander_reset_i)
      expander_q <= 16'h0000;
    else
      expander_q <= pattern_i;
  end
  // Disabled buffer leaves pins to the pull-downs, so they read low
  assign strap_o = strap_buffer_enable_n ? 16'h0000 : (expander_q | switches);

  // Reset lines; power-off also drops the supply-derived cold reset
  assign cold_reset_n_o = automation_cold_reset_n_i & ~automation_power_off_i;
  assign main_warm_reset_n_o = automation_warm_reset_n_i;
endmodule

// ### verification/tb.sv
// Self-checking bench for the boot-strap decoder
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] pattern = 16'h0000;
  logic load = 1'b0;
  logic exp_rst = 1'b0;
  logic cold_n = 1'b0;
  logic warm_n = 1'b1;
  logic power_off = 1'b0;
  logic boot_ok_i = 1'b0;
  logic boot_fail_i = 1'b0;
  logic [15:0] strap;
  logic cold_pin_n;
  logic warm_pin_n;
  logic strap_valid_o;
  logic [2:0] pll_ref_sel_o;
  logic pll_ref_rsvd_o;
  logic [3:0] primary_sel_o;
  logic primary_rsvd_o;
  logic [2:0] primary_cfg_o;
  logic [2:0] backup_sel_o;
  logic backup_rsvd_o;
  logic backup_cfg_o;
  wire logic [3:0] sts;
  int err_count = 0;
  int comparisons = 0;

  bsd_board u_bsd_board (.pattern_i(pattern), .load_i(load), .strap_expander_reset_i(exp_rst),
    .automation_cold_reset_n_i(cold_n), .automation_warm_reset_n_i(warm_n),
    .automation_power_off_i(power_off), .strap_o(strap), .cold_reset_n_o(cold_pin_n),
    .main_warm_reset_n_o(warm_pin_n));
  bsd_top u_bsd_top (.clk_i(clk_i), .rst_i(rst_i), .strap_i(strap), .cold_reset_n_i(cold_pin_n),
    .main_warm_reset_n_i(warm_pin_n), .boot_ok_i(boot_ok_i), .boot_fail_i(boot_fail_i),
    .strap_valid_o(strap_valid_o), .pll_ref_sel_o(pll_ref_sel_o), .pll_ref_rsvd_o(pll_ref_rsvd_o),
    .primary_sel_o(primary_sel_o), .primary_rsvd_o(primary_rsvd_o),
    .primary_cfg_o(primary_cfg_o), .backup_sel_o(backup_sel_o), .backup_rsvd_o(backup_rsvd_o),
    .backup_cfg_o(backup_cfg_o), .try_primary_o(sts[3]), .try_backup_o(sts[2]),
    .boot_done_o(sts[1]), .boot_halt_o(sts[0]));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  function automatic logic pri_rsvd(input logic [3:0] p);
    return p == 4'h0 || p == 4'h4 || p == 4'h5;
  endfunction
  function automatic logic bak_ok(input logic [2:0] b);
    return b != 3'h0 && b != 3'h2 && b != 3'h4;
  endfunction

  // Expander reset, pattern load under cold reset, then release and wait
  task automatic cold_cycle(input logic [15:0] w);
    int n;
    @(negedge clk_i);
    cold_n = 1'b0;
    exp_rst = 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK("valid_low", 1'b0, strap_valid_o)
    `CHK("seq_low", 4'h0, sts)
    exp_rst = 1'b0;
    pattern = w;
    load = 1'b1;
    @(negedge clk_i);
    load = 1'b0;
    cold_n = 1'b1;
    n = 0;
    while (strap_valid_o !== 1'b1 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    `CHK("valid", 1'b1, strap_valid_o)
  endtask

  // Field decode and boot sequencing for one strap word
  task automatic decode_case(input logic [3:0] i);
    logic [15:0] w;
    logic [3:0] st;
    logic ok;
    w = {2'b10, i[3], i[2:0], ~i[2:0], i, i[2:0]};
    cold_cycle(w);
    `CHK("pll", i[2:0], pll_ref_sel_o)
    `CHK("pll_rsvd", i[2] & i[1], pll_ref_rsvd_o)
    `CHK("pri", i, primary_sel_o)
    `CHK("pri_rsvd", pri_rsvd(i), primary_rsvd_o)
    `CHK("pcfg", ~i[2:0], primary_cfg_o)
    `CHK("bak", i[2:0], backup_sel_o)
    `CHK("bak_rsvd", i[2:0] == 3'h2 || i[2:0] == 3'h4, backup_rsvd_o)
    `CHK("bcfg", i[3] & (i[2:0] == 3'h1 || i[2:0] == 3'h5), backup_cfg_o)
    repeat (2) @(negedge clk_i);
    if (i == 4'hf)
      st = 4'b0001;
    else if (!pri_rsvd(i))
      st = 4'b1000;
    else
      st = bak_ok(i[2:0]) ? 4'b0100 : 4'b0001;
    `CHK("start", st, sts)
    // Result lines are set once per falling edge and cleared only after the last step
    while (st[3] | st[2])
    begin
      ok = st[2] ? i[0] : (i == 4'hd);
      boot_ok_i = ok;
      boot_fail_i = ~ok;
      @(negedge clk_i);
      st = ok ? 4'b0010 : (st[3] & bak_ok(i[2:0])) ? 4'b0100 : 4'b0001;
      `CHK("step", st, sts)
    end
    boot_ok_i = 1'b0;
    boot_fail_i = 1'b0;
  endtask

  // Warm reset keeps the word; late strap changes and power-off
  task automatic warm_keep;
    cold_cycle(16'h040b);
    warm_n = 1'b0;
    repeat (8) @(negedge clk_i);
    `CHK("warm_seq", 4'h0, sts)
    pattern = 16'h3ff6;
    load = 1'b1;
    @(negedge clk_i);
    load = 1'b0;
    warm_n = 1'b1;
    repeat (8) @(negedge clk_i);
    `CHK("keep_pll", 3'h3, pll_ref_sel_o)
    `CHK("keep_pri", 4'h1, primary_sel_o)
    `CHK("restart", 4'b1000, sts)
    power_off = 1'b1;
    repeat (8) @(negedge clk_i);
    `CHK("pwr_off", 1'b0, strap_valid_o)
    power_off = 1'b0;
  endtask

  task automatic stop_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    `CHK("rst_valid", 1'b0, strap_valid_o)
    for (int k = 0; k < 16; k++)
      decode_case(4'(k));
    warm_keep();
    stop_test();
  end

  // Watchdog: the run needs about 310 cycles, so 2000 cycles means a hang
  initial
  begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule
